// file: src/trig_pkg.sv
// Shared constants of the current trigger detector: register map,
// control field positions, reset values and widths.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package trig_pkg;

  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int CUR_W     = 16;
  localparam int TIME_W    = 24;
  localparam int PULSE_W   = 16;
  localparam int NUM_MON   = 16;
  localparam int MON_IDX_W = 4;
  localparam int IRQ_W     = 2;
  localparam int SYNC_N    = 3;

  // Register byte offsets; monitoring-point regions are coded in address bits 7:6
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_THRESH   = 8'h04;
  localparam logic [7:0] OFS_CUR_LO   = 8'h08;
  localparam logic [7:0] OFS_CUR_HI   = 8'h0C;
  localparam logic [7:0] OFS_TIME_LIM = 8'h10;
  localparam logic [7:0] OFS_TIME_LO  = 8'h14;
  localparam logic [7:0] OFS_TIME_HI  = 8'h18;
  localparam logic [7:0] OFS_PULSE    = 8'h1C;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h28;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h2C;
  localparam logic [7:0] OFS_MON_EN   = 8'h30;
  localparam logic [7:0] OFS_NOW      = 8'h34;
  localparam logic [1:0] OFS_MON_ADDR = 2'h1;
  localparam logic [1:0] OFS_MON_TS   = 2'h2;

  // Control register fields
  localparam int CTRL_MEAS_EN  = 0;
  localparam int CTRL_CMP_LSB  = 1;
  localparam int CTRL_DUR_EN   = 3;
  localparam int CTRL_DUR_WIN  = 4;
  localparam int CTRL_ACT_OUT  = 5;
  localparam int CTRL_OUT_CH   = 6;
  localparam int CTRL_OUT_LVL  = 7;
  localparam int CTRL_GATE_EN  = 8;
  localparam int CTRL_GATE_CH  = 9;
  localparam int CTRL_GATE_LVL = 10;
  localparam int CTRL_W        = 11;

  // Comparison modes
  localparam logic [1:0] CMP_OVER    = 2'h0;
  localparam logic [1:0] CMP_UNDER   = 2'h1;
  localparam logic [1:0] CMP_INSIDE  = 2'h2;
  localparam logic [1:0] CMP_OUTSIDE = 2'h3;

  // Interrupt status bits
  localparam int IRQ_TRIG = 0;
  localparam int IRQ_MON  = 1;

  // Reset values and bus response codes
  localparam logic [CTRL_W-1:0]  CTRL_RST  = 11'h000;
  localparam logic [CUR_W-1:0]   CUR_RST   = 16'h0000;
  localparam logic [TIME_W-1:0]  TIME_RST  = 24'h00_0000;
  localparam logic [PULSE_W-1:0] PULSE_RST = 16'h0001;
  localparam logic [1:0]         RESP_OK   = 2'h0;
  localparam logic [1:0]         RESP_ERR  = 2'h2;

endpackage

// file: src/pin_sync.sv
// Three-stage synchroniser for asynchronous pin inputs, one per bit.
// A change is passed on once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // Pins and filtered levels
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [trig_pkg::SYNC_N-1:0] stage_q;
    logic                        level_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        stage_q <= '0;
        level_q <= 1'b0;
      end else if (ce) begin
        stage_q <= {stage_q[trig_pkg::SYNC_N-2:0], pin[i]};
        // Only stages two and three are looked at
        if (stage_q[1] == stage_q[2]) begin
          level_q <= stage_q[2];
        end
      end
    end
    assign level[i] = level_q;
  end

endmodule
`default_nettype wire

// file: src/stamp_mem.sv
// Small memory for monitoring-point timestamps, one word per point.
// Read data come out of a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module stamp_mem (
  // Clock
  input  wire logic                             aclk,
  input  wire logic                             ce,
  // Write port
  input  wire logic                             we,
  input  wire logic [trig_pkg::MON_IDX_W-1:0]   waddr,
  input  wire logic [trig_pkg::DATA_W-1:0]      wdata,
  // Read port
  input  wire logic [trig_pkg::MON_IDX_W-1:0]   raddr,
  output logic      [trig_pkg::DATA_W-1:0]      rdata
);

  logic [trig_pkg::DATA_W-1:0] mem [trig_pkg::NUM_MON];

  always_ff @(posedge aclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (ce) begin
      rdata <= mem[raddr];
    end
  end

endmodule
`default_nettype wire

// file: src/current_trigger_detector.sv
// Current trigger detector: compares supply-current samples against a
// threshold or window, optionally qualified by duration, and then
// requests a halt or drives one of two external trigger outputs.
// Also timestamps monitoring-point passes on the sample timeline.
// Assumes samples and program-counter reports arrive on aclk; the
// external trigger inputs are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Four comparison modes: over, under, inside window, outside window.
// - Over/under use one threshold; inside/outside use lower and upper limits.
// - Optional duration qualifier counts how long the condition held.
// - Duration mode is a single limit or a lower/upper limit window.
// - Duration counts advance once per accepted current sample.
// - A satisfied trigger either requests a halt or drives a trigger output.
// - Two trigger outputs; configuration picks which one is driven.
// - Output is a configurable-width high pulse or a level while the trigger stays qualified (qual_q).
// - Window duration fires on the sample the condition ends, inside the window.
// - Up to sixteen monitoring points are active at once.
// - Each monitoring-point pass records a sample-timeline timestamp for the lowest-numbered point it hits.
// - A selected trigger input at its active level gates sample acquisition.
module current_trigger_detector (
  // Clock, reset and clock enable
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          ce,
  // AXI4-Lite write address
  input  wire logic [trig_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [trig_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]                    s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [trig_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  // AXI4-Lite read data
  output logic      [trig_pkg::DATA_W-1:0]   s_axi_rdata,
  output logic      [1:0]                    s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // Current samples from the measurement front end
  input  wire logic                          sample_valid,
  input  wire logic [trig_pkg::CUR_W-1:0]    sample_data,
  // Program-counter reports from the debug core
  input  wire logic                          pc_valid,
  input  wire logic [trig_pkg::DATA_W-1:0]   pc_addr,
  // External trigger pins
  input  wire logic [1:0]                    ext_trig_in,
  output logic      [1:0]                    ext_trig_out,
  // Break request and interrupt
  output logic                               halt_req,
  output logic                               irq
);

  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} rd_state_type;

  // Software-visible state
  logic [trig_pkg::CTRL_W-1:0]    ctrl_q;
  logic [trig_pkg::CUR_W-1:0]     thresh_q;
  logic [trig_pkg::CUR_W-1:0]     cur_lo_q;
  logic [trig_pkg::CUR_W-1:0]     cur_hi_q;
  logic [trig_pkg::TIME_W-1:0]    time_lim_q;
  logic [trig_pkg::TIME_W-1:0]    time_lo_q;
  logic [trig_pkg::TIME_W-1:0]    time_hi_q;
  logic [trig_pkg::PULSE_W-1:0]   pulse_w_q;
  logic [trig_pkg::IRQ_W-1:0]     irq_stat_q;
  logic [trig_pkg::IRQ_W-1:0]     irq_en_q;
  logic [trig_pkg::NUM_MON-1:0]   mon_en_q;
  logic [trig_pkg::DATA_W-1:0]    mon_addr_q [trig_pkg::NUM_MON];
  logic [trig_pkg::DATA_W-1:0]    now_q;

  // Bus slave state
  logic                           aw_full_q;
  logic [trig_pkg::ADDR_W-1:0]    aw_addr_q;
  logic                           w_full_q;
  logic [trig_pkg::DATA_W-1:0]    w_data_q;
  logic [3:0]                     w_strb_q;
  logic                           bvalid_q;
  logic [1:0]                     bresp_q;
  rd_state_type                   rd_st_q;
  logic [trig_pkg::ADDR_W-1:0]    ar_addr_q;
  logic [trig_pkg::DATA_W-1:0]    rdata_q;
  logic [1:0]                     rresp_q;
  logic                           do_write;

  // Trigger datapath state
  logic                           cond_q;
  logic                           qual_q;
  logic [trig_pkg::TIME_W-1:0]    dur_q;
  logic [trig_pkg::PULSE_W-1:0]   pulse_cnt_q;
  logic [1:0]                     trig_out_q;
  logic                           halt_q;
  logic                           irq_q;

  // Combinational terms
  logic [1:0]                     trig_in_s;
  logic                           meas_en;
  logic [1:0]                     cmp_mode;
  logic                           dur_en;
  logic                           dur_win;
  logic                           act_out;
  logic                           out_ch;
  logic                           out_lvl;
  logic                           gate_ok;
  logic                           samp_take;
  logic                           cond;
  logic [trig_pkg::TIME_W-1:0]    dur_cur;
  logic                           fire;
  logic                           qual;
  logic                           fire_ev;
  logic [trig_pkg::NUM_MON-1:0]   mon_hit;
  logic                           mon_ev;
  logic [trig_pkg::DATA_W-1:0]    ts_rdata;
  logic [trig_pkg::IRQ_W-1:0]     irq_set;
  logic [trig_pkg::IRQ_W-1:0]     irq_clr;

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (data & m);
  endfunction

  // Decodes whether an address is mapped; shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    logic hit;
    hit = (a[7:6] == trig_pkg::OFS_MON_ADDR) || (a[7:6] == trig_pkg::OFS_MON_TS);
    if (a <= trig_pkg::OFS_NOW) begin
      hit = 1'b1;
    end
    return hit && (a[1:0] == 2'h0);
  endfunction

  // Lowest-numbered hit monitoring point
  function automatic logic [3:0] first_hit(input logic [15:0] h);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (h[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .pin     (ext_trig_in),
    .level   (trig_in_s)
  );

  assign meas_en  = ctrl_q[trig_pkg::CTRL_MEAS_EN];
  assign cmp_mode = ctrl_q[trig_pkg::CTRL_CMP_LSB +: 2];
  assign dur_en   = ctrl_q[trig_pkg::CTRL_DUR_EN];
  assign dur_win  = ctrl_q[trig_pkg::CTRL_DUR_WIN];
  assign act_out  = ctrl_q[trig_pkg::CTRL_ACT_OUT];
  assign out_ch   = ctrl_q[trig_pkg::CTRL_OUT_CH];
  assign out_lvl  = ctrl_q[trig_pkg::CTRL_OUT_LVL];

  // Acquisition gate on the selected trigger input level
  assign gate_ok = !ctrl_q[trig_pkg::CTRL_GATE_EN] ||
                   (trig_in_s[ctrl_q[trig_pkg::CTRL_GATE_CH]] ==
                    ctrl_q[trig_pkg::CTRL_GATE_LVL]);
  // One evaluation per accepted sample
  assign samp_take = sample_valid && meas_en && gate_ok;

  // Current comparison
  always_comb begin
    unique case (cmp_mode)
      trig_pkg::CMP_OVER:    cond = sample_data > thresh_q;
      trig_pkg::CMP_UNDER:   cond = sample_data < thresh_q;
      trig_pkg::CMP_INSIDE:  cond = (sample_data >= cur_lo_q) && (sample_data <= cur_hi_q);
      trig_pkg::CMP_OUTSIDE: cond = (sample_data < cur_lo_q) || (sample_data > cur_hi_q);
    endcase
  end

  // Run length including this sample, saturating
  assign dur_cur = !cond ? '0 : (&dur_q) ? dur_q : dur_q + 1'b1;

  // Trigger decision
  always_comb begin
    if (!dur_en) begin
      fire = cond && !cond_q;
      qual = cond;
    end else if (!dur_win) begin
      fire = cond && (dur_cur == time_lim_q) && (dur_cur != dur_q);
      qual = cond && (dur_cur >= time_lim_q) && (time_lim_q != '0);
    end else begin
      // Fires only on the sample where a qualifying run ends
      fire = !cond && cond_q && (dur_q >= time_lo_q) && (dur_q < time_hi_q);
      qual = fire;
    end
  end
  assign fire_ev = samp_take && fire;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_q <= 1'b0;
      qual_q <= 1'b0;
      dur_q  <= '0;
    end else if (ce) begin
      if (!meas_en) begin
        cond_q <= 1'b0;
        qual_q <= 1'b0;
        dur_q  <= '0;
      end else if (samp_take) begin
        cond_q <= cond;
        qual_q <= qual;
        dur_q  <= dur_cur;
      end
    end
  end

  // Sample timeline used for timestamps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      now_q <= '0;
    end else if (ce && samp_take) begin
      now_q <= now_q + 1'b1;
    end
  end

  // Halt request and pulse timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_q      <= 1'b0;
      pulse_cnt_q <= '0;
    end else if (ce) begin
      halt_q <= fire_ev && !act_out;
      if (!meas_en) begin
        pulse_cnt_q <= '0;
      end else if (fire_ev && act_out && !out_lvl) begin
        pulse_cnt_q <= pulse_w_q;
      end else if (pulse_cnt_q != '0) begin
        pulse_cnt_q <= pulse_cnt_q - 1'b1;
      end
    end
  end

  // Drive only the selected channel; both low when disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_out_q <= 2'h0;
    end else if (ce) begin
      if (meas_en && act_out && (out_lvl ? qual_q : (pulse_cnt_q != '0))) begin
        trig_out_q <= out_ch ? 2'h2 : 2'h1;
      end else begin
        trig_out_q <= 2'h0;
      end
    end
  end

  // Monitoring-point address match, sixteen comparators
  for (genvar i = 0; i < trig_pkg::NUM_MON; i++) begin : g_mon
    assign mon_hit[i] = mon_en_q[i] && pc_valid && (pc_addr == mon_addr_q[i]);
  end
  assign mon_ev = |mon_hit;

  // A pass stores the current sample count for that point
  stamp_mem u_stamps (
    .aclk  (aclk),
    .ce    (ce),
    .we    (mon_ev),
    .waddr (first_hit(mon_hit)),
    .wdata (now_q),
    .raddr (s_axi_araddr[5:2]),
    .rdata (ts_rdata)
  );

  // Sticky interrupt status; a new event wins over a clear
  assign irq_set = {mon_ev, fire_ev};
  assign irq_clr = (do_write && aw_addr_q == trig_pkg::OFS_IRQ_CLR) ?
                   w_data_q[trig_pkg::IRQ_W-1:0] & {trig_pkg::IRQ_W{w_strb_q[0]}} : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq_q      <= 1'b0;
    end else if (ce) begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_q      <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
    end
  end

  // Write channel capture; address and data may come in either order
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;
  assign do_write      = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= trig_pkg::RESP_OK;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= mapped(aw_addr_q) ? trig_pkg::RESP_OK : trig_pkg::RESP_ERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= trig_pkg::CTRL_RST;
      thresh_q   <= trig_pkg::CUR_RST;
      cur_lo_q   <= trig_pkg::CUR_RST;
      cur_hi_q   <= trig_pkg::CUR_RST;
      time_lim_q <= trig_pkg::TIME_RST;
      time_lo_q  <= trig_pkg::TIME_RST;
      time_hi_q  <= trig_pkg::TIME_RST;
      pulse_w_q  <= trig_pkg::PULSE_RST;
      irq_en_q   <= '0;
      mon_en_q   <= '0;
      for (int i = 0; i < trig_pkg::NUM_MON; i++) begin
        mon_addr_q[i] <= '0;
      end
    end else if (ce && do_write) begin
      unique case (aw_addr_q)
        trig_pkg::OFS_CTRL: begin
          ctrl_q <= trig_pkg::CTRL_W'(merge(32'(ctrl_q), w_data_q, w_strb_q));
        end
        trig_pkg::OFS_THRESH: begin
          thresh_q <= trig_pkg::CUR_W'(merge(32'(thresh_q), w_data_q, w_strb_q));
        end
        trig_pkg::OFS_CUR_LO: begin
          cur_lo_q <= trig_pkg::CUR_W'(merge(32'(cur_lo_q), w_data_q, w_strb_q));
        end
        trig_pkg::OFS_CUR_HI: begin
          cur_hi_q <= trig_pkg::CUR_W'(merge(32'(cur_hi_q), w_data_q, w_strb_q));
        end
        trig_pkg::OFS_TIME_LIM: begin
          time_lim_q <= trig_pkg::TIME_W'(merge(32'(time_lim_q), w_data_q, w_strb_q));
        end
        trig_pkg::OFS_TIME_LO: begin
          time_lo_q <= trig_pkg::TIME_W'(merge(32'(time_lo_q), w_data_q, w_strb_q));
        end
        trig_pkg::OFS_TIME_HI: begin
          time_hi_q <= trig_pkg::TIME_W'(merge(32'(time_hi_q), w_data_q, w_strb_q));
        end
        trig_pkg::OFS_PULSE: begin
          pulse_w_q <= trig_pkg::PULSE_W'(merge(32'(pulse_w_q), w_data_q, w_strb_q));
        end
        trig_pkg::OFS_IRQ_EN: begin
          irq_en_q <= trig_pkg::IRQ_W'(merge(32'(irq_en_q), w_data_q, w_strb_q));
        end
        trig_pkg::OFS_MON_EN: begin
          mon_en_q <= trig_pkg::NUM_MON'(merge(32'(mon_en_q), w_data_q, w_strb_q));
        end
        default: begin
          if (aw_addr_q[7:6] == trig_pkg::OFS_MON_ADDR) begin
            mon_addr_q[aw_addr_q[5:2]] <= merge(mon_addr_q[aw_addr_q[5:2]], w_data_q,
                                                w_strb_q);
          end
        end
      endcase
    end
  end

  // Read path: fixed two-cycle latency covers the registered stamp memory
  assign s_axi_arready = (rd_st_q == RD_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_st_q   <= RD_IDLE;
      ar_addr_q <= '0;
      rdata_q   <= '0;
      rresp_q   <= trig_pkg::RESP_OK;
    end else if (ce) begin
      unique case (rd_st_q)
        RD_IDLE: begin
          if (s_axi_arvalid) begin
            ar_addr_q <= s_axi_araddr;
            rd_st_q   <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          rresp_q <= mapped(ar_addr_q) ? trig_pkg::RESP_OK : trig_pkg::RESP_ERR;
          rd_st_q <= RD_RESP;
          unique case (ar_addr_q)
            trig_pkg::OFS_CTRL:     rdata_q <= 32'(ctrl_q);
            trig_pkg::OFS_THRESH:   rdata_q <= 32'(thresh_q);
            trig_pkg::OFS_CUR_LO:   rdata_q <= 32'(cur_lo_q);
            trig_pkg::OFS_CUR_HI:   rdata_q <= 32'(cur_hi_q);
            trig_pkg::OFS_TIME_LIM: rdata_q <= 32'(time_lim_q);
            trig_pkg::OFS_TIME_LO:  rdata_q <= 32'(time_lo_q);
            trig_pkg::OFS_TIME_HI:  rdata_q <= 32'(time_hi_q);
            trig_pkg::OFS_PULSE:    rdata_q <= 32'(pulse_w_q);
            trig_pkg::OFS_STATUS:   rdata_q <= 32'({trig_out_q, halt_q, qual_q, cond_q,
                                                    trig_in_s});
            trig_pkg::OFS_IRQ_STAT: rdata_q <= 32'(irq_stat_q);
            trig_pkg::OFS_IRQ_EN:   rdata_q <= 32'(irq_en_q);
            trig_pkg::OFS_MON_EN:   rdata_q <= 32'(mon_en_q);
            trig_pkg::OFS_NOW:      rdata_q <= now_q;
            default: begin
              if (ar_addr_q[7:6] == trig_pkg::OFS_MON_ADDR) begin
                rdata_q <= mon_addr_q[ar_addr_q[5:2]];
              end else if (ar_addr_q[7:6] == trig_pkg::OFS_MON_TS) begin
                rdata_q <= ts_rdata;
              end else begin
                rdata_q <= '0;
              end
            end
          endcase
        end
        RD_RESP: begin
          if (s_axi_rready) begin
            rd_st_q <= RD_IDLE;
          end
        end
        default: rd_st_q <= RD_IDLE;
      endcase
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = (rd_st_q == RD_RESP);
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;
  assign ext_trig_out = trig_out_q;
  assign halt_req     = halt_q;
  assign irq          = irq_q;

endmodule
`default_nettype wire

// file: tb/trig_monitor.sv
// Port checks of the detector: bus handshakes and trigger timing.
// Assumes ce stays high, so every clock edge is a design cycle.
`timescale 1ns/1ps
`default_nettype none
module trig_monitor (
  // Clock, reset and handshakes
  input wire logic       aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input wire logic       s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
  input wire logic       s_axi_arready, s_axi_rvalid, sample_valid, halt_req,
  // Trigger pins
  input wire logic [1:0] ext_trig_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write response");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("response repeated");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("late read data");
  a_read_take: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("read taken twice");
  a_halt_pulse: assert property (halt_req |=> !halt_req)
    else $error("halt request too long");
  a_halt_cause: assert property ($rose(halt_req) |-> $past(sample_valid))
    else $error("halt without sample");
  a_chan_onehot: assert property (ext_trig_out != 2'b11)
    else $error("both trigger pins high");
  a_out_cause: assert property ($rose(ext_trig_out[0]) || $rose(ext_trig_out[1])
    |-> $past(sample_valid, 2)) else $error("pin without sample");
endmodule
bind current_trigger_detector trig_monitor i_mon (.*);
`default_nettype wire

// file: tb/trig_watch.sv
// Far side: bench equipment counting pulses on the two trigger pins.
// Assumes the pins change only on the detector clock.
`timescale 1ns/1ps
`default_nettype none
module trig_watch (
  // Clock and pins
  input  wire logic        aclk,
  input  wire logic [1:0]  pin,
  // What was seen
  output logic      [7:0]  h0 = 8'h00,
  output logic      [7:0]  h1 = 8'h00,
  output logic      [15:0] width = 16'h0000
);
  logic [1:0]  last_q = 2'b00;
  logic [15:0] run_q = 16'h0000;
  always @(posedge aclk) begin
    if (pin[0] && !last_q[0]) h0 <= h0 + 8'h01;
    if (pin[1] && !last_q[1]) h1 <= h1 + 8'h01;
    // Width is known only once the pin falls; a level still held never reports
    if (|pin) run_q <= run_q + 16'h0001;
    else if (|last_q) begin
      width <= run_q;
      run_q <= 16'h0000;
    end
    last_q <= pin;
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Bench: one task a scenario over the register bus and sample input.
// Assumes ce, strobes and readies stay fixed.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, sample_valid = 1'b0;
  logic pc_valid = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, halt_req, irq;
  logic [1:0] ext_trig_in = 2'b00, s_axi_bresp, s_axi_rresp, ext_trig_out, rsp;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, h0, h1;
  logic [15:0] sample_data = 16'h0000, pw;
  logic [31:0] s_axi_wdata = 32'h0000_0000, pc_addr = 32'h0000_0000, s_axi_rdata, rdv;
  int bad_count = 0, compares = 0, nsamp = 0, halts = 0;
  current_trigger_detector i_dut (.*);
  trig_watch i_watch (.aclk(aclk), .pin(ext_trig_out), .h0(h0), .h1(h1), .width(pw));
  initial forever #20 aclk = ~aclk;
  always @(posedge aclk) if (halt_req === 1'b1) halts++;
  task automatic final_report;
    $display("Compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    if (w) {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    else s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w ? s_axi_bvalid : s_axi_rvalid) break;
    end
    rsp = w ? s_axi_bresp : s_axi_rresp;
    rdv = s_axi_rdata;
    if (n == 40) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic smp(input logic [15:0] v);
    @(posedge aclk);
    sample_data <= v;
    sample_valid <= 1'b1;
    @(posedge aclk);
    sample_valid <= 1'b0;
    nsamp++;
  endtask
  task automatic settle;
    repeat (8) @(posedge aclk);
  endtask
  task automatic s_regs;
    bus(0, 8'h1C, 32'h0000_0000);
    `CHK(rdv, 32'h0000_0001)
    bus(0, 8'h3C, 32'h0000_0000);
    `CHK(rsp, trig_pkg::RESP_ERR)
    bus(1, 8'h3C, 32'h0000_0001);
    `CHK(rsp, trig_pkg::RESP_ERR)
  endtask
  task automatic s_over;
    bus(1, 8'h04, 32'h0000_0064);
    bus(1, 8'h1C, 32'h0000_0003);
    bus(1, 8'h00, 32'h0000_0061);
    smp(16'h0032);
    smp(16'h00C8);
    settle();
    `CHK({h1, h0}, 16'h0100)
    `CHK(pw, 16'h0003)
    `CHK(irq, 1'b0)
    bus(1, 8'h2C, 32'h0000_0001);
    settle();
    `CHK(irq, 1'b1)
    bus(1, 8'h28, 32'h0000_0001);
    settle();
    `CHK(irq, 1'b0)
    smp(16'h0000);
  endtask
  task automatic s_win;
    int lens[3] = '{2, 4, 5};
    bus(1, 8'h08, 32'h0000_000A);
    bus(1, 8'h0C, 32'h0000_0014);
    bus(1, 8'h14, 32'h0000_0003);
    bus(1, 8'h18, 32'h0000_0005);
    bus(1, 8'h00, 32'h0000_003D);
    for (int i = 0; i < 3; i++) begin
      repeat (lens[i]) smp(16'h000F);
      smp(16'h0000);
    end
    settle();
    `CHK({h1, h0}, 16'h0101)
  endtask
  task automatic s_halt;
    bus(1, 8'h00, 32'h0000_0003);
    smp(16'h00C8);
    smp(16'h0032);
    settle();
    `CHK(halts, 1)
    `CHK({h1, h0}, 16'h0101)
  endtask
  task automatic s_mon;
    bus(1, 8'h7C, 32'h0000_1234);
    bus(1, 8'h30, 32'h0000_8000);
    @(posedge aclk);
    pc_addr <= 32'h0000_1234;
    pc_valid <= 1'b1;
    @(posedge aclk);
    pc_valid <= 1'b0;
    bus(0, 8'hBC, 32'h0000_0000);
    `CHK(rdv, 32'(nsamp))
  endtask
  task automatic s_gate;
    bus(1, 8'h00, 32'h0000_0000);
    bus(1, 8'h10, 32'h0000_0002);
    bus(1, 8'h00, 32'h0000_05EF);
    repeat (2) smp(16'h0000);
    ext_trig_in <= 2'b01;
    settle();
    smp(16'h0000);
    settle();
    `CHK(h1, 8'h01)
    smp(16'h0000);
    settle();
    bus(0, 8'h20, 32'h0000_0000);
    `CHK(rdv, 32'h0000_004D)
    bus(1, 8'h00, 32'h0000_0000);
    settle();
    `CHK(ext_trig_out, 2'b00)
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    s_regs();
    s_over();
    s_win();
    s_halt();
    s_mon();
    s_gate();
    final_report();
  end
endmodule
`default_nettype wire
